//--- hw/rdirq_top.sv
/*
 * Request-status, enable and buffer-port registers of a reader frontend,
 * with the interrupt pin driver and the buffer fill counter.
 * Assumes the buffer storage sits outside and shows its head byte on
 * FIFO_RDATA; all inputs come from logic on SYS_CLK.
 */
// Contract
// - Fill count low byte readable, reset zero; upper bits go to buffer control
// - Data port write pushes and counts up; read pops and counts down
// - Address pointer does not advance on data port accesses
// - Status write: bit 7 picks set or clear for each marked bit
// - Second status register: mechanism touches bits 5 to 0 only
// - High-level request latches on rising live high condition
// - Low-level request latches on rising live low condition
// - Command-done request set on self end or unknown command
// - Host writing the idle command sets no command-done request
// - Transmit-done request set after last transmitted bit
// - Receive-done request set at end of incoming stream
// - Error request set when any of five error flags rises
// - Frame-start request set on start symbol or subcarrier
// - Combined request high whenever an enabled request is present
// - Card-detect request set when card detection finds a card
// - Timer requests 4 to 0 set on matching timer underflow
// - Enable A bits 6 to 0 gate first group into combined request
// - Enable A bit 7 inverts the interrupt pin polarity
// - Combined request reaches pin only while enable B bit 6 set
// - Enable B bit 7 picks push-pull, else open-drain driver
// - Enable B bits 5 to 0 gate card-detect and timer requests
// - Live low: fill at most level; live high: capacity minus fill at most level
`timescale 1ns/1ps

module rdirq_top
    import rdirq_pkg::*;
#(
    parameter int FILL_W = 10
) (
    input  wire logic          SYS_CLK,
    input  wire logic          RST_N,
    input  wire logic          HOST_ADDR_LD,
    input  wire logic [7:0]    HOST_ADDR,
    input  wire logic          HOST_WR,
    input  wire logic          HOST_RD,
    input  wire logic [7:0]    HOST_WDATA,
    output logic      [7:0]    HOST_RDATA,
    output logic               HOST_RVALID,
    output logic               FIFO_PUSH,
    output logic      [7:0]    FIFO_WDATA,
    output logic               FIFO_POP,
    input  wire logic [7:0]    FIFO_RDATA,
    input  wire logic          FIFO_FLUSH,
    input  wire logic          BUF_SIZE_SEL,
    input  wire logic [8:0]    LEVEL_THRESHOLD,
    output logic      [1:0]    FILL_COUNT_EXT,
    output logic               HIGH_LEVEL_LIVE,
    output logic               LOW_LEVEL_LIVE,
    input  wire rdirq_events_s EVENTS,
    output logic               COMBINED_REQUEST,
    output logic               IRQ_O,
    output logic               IRQ_OE
);

    rdirq_state_s q;
    rdirq_state_s d;

    logic [7:0]               acc_addr;
    logic                     wr;
    logic                     rd;
    logic                     data_wr;
    logic                     data_rd;
    logic [9:0]               cap;
    logic [9:0]               thr;
    logic                     push_ok;
    logic                     pop_ok;
    logic                     hi_live;
    logic                     lo_live;
    logic [RDIRQ_REQ_A_W-1:0] set_a;
    logic [RDIRQ_REQ_B_W-1:0] set_b;
    logic [RDIRQ_REQ_A_W-1:0] req_a;
    logic [RDIRQ_REQ_B_W-1:0] req_b;
    logic                     combined;
    logic                     pin_active;
    logic                     pin_level;

    // Elaboration check on the counter width
    if (FILL_W != 10) begin : g_bad_fill
        $error("Fill counter must be 10 bits wide");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode and live level conditions
    always_comb begin
        acc_addr = HOST_ADDR_LD ? HOST_ADDR : q.ptr;
        wr       = HOST_WR;
        rd       = HOST_RD & ~HOST_WR;                 // Write wins a clash
        data_wr  = wr & (acc_addr == RDIRQ_ADDR_DATA);
        data_rd  = rd & (acc_addr == RDIRQ_ADDR_DATA);
        cap      = BUF_SIZE_SEL ? RDIRQ_CAP_SMALL : RDIRQ_CAP_LARGE;
        thr      = BUF_SIZE_SEL ? {2'h0, LEVEL_THRESHOLD[7:0]} : {1'b0, LEVEL_THRESHOLD};
        push_ok  = data_wr & (q.fill < cap);
        pop_ok   = data_rd & (q.fill != 10'h000);
        lo_live  = q.fill <= thr;
        hi_live  = (cap - q.fill) <= thr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware set events for both request banks
    always_comb begin
        set_a[6] = hi_live & ~q.hi_prev;
        set_a[5] = lo_live & ~q.lo_prev;
        set_a[4] = EVENTS.cmd_self_end | EVENTS.cmd_unknown;
        set_a[3] = EVENTS.tx_done;
        set_a[2] = EVENTS.rx_done;
        set_a[1] = |(EVENTS.error_flags & ~q.err_prev);
        set_a[0] = EVENTS.frame_start;
        set_b    = {EVENTS.card_detect, EVENTS.timer_underflow};
    end

    rdirq_req_bank #(
        .W       (RDIRQ_REQ_A_W)
    ) u_bank_a (
        .sys_clk (SYS_CLK),
        .rst_n   (RST_N),
        .wr      (wr & (acc_addr == RDIRQ_ADDR_STAT_A)),
        .wdata   (HOST_WDATA),
        .set_ev  (set_a),
        .req     (req_a)
    );

    // Only bits 5 to 0 live in this bank; bit 6 is the combined request
    rdirq_req_bank #(
        .W       (RDIRQ_REQ_B_W)
    ) u_bank_b (
        .sys_clk (SYS_CLK),
        .rst_n   (RST_N),
        .wr      (wr & (acc_addr == RDIRQ_ADDR_STAT_B)),
        .wdata   (HOST_WDATA),
        .set_ev  (set_b),
        .req     (req_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Combined request and pin level
    always_comb begin
        combined   = |(req_a & q.en_a[RDIRQ_REQ_A_W-1:0])
                   | |(req_b & q.en_b[RDIRQ_REQ_B_W-1:0]);
        pin_active = combined & q.en_b[RDIRQ_PINEN_BIT];
        pin_level  = pin_active ^ q.en_a[RDIRQ_INV_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d        = q;
        d.push   = data_wr;
        d.wdata  = HOST_WDATA;
        d.rvalid = rd;
        d.hi_prev  = hi_live;
        d.lo_prev  = lo_live;
        d.err_prev = EVENTS.error_flags;

        // Pointer stays on the data port, advances elsewhere
        if (wr | rd) begin
            if (acc_addr == RDIRQ_ADDR_DATA) begin
                d.ptr = acc_addr;
            end else begin
                d.ptr = acc_addr + 8'h01;
            end
        end else if (HOST_ADDR_LD) begin
            d.ptr = HOST_ADDR;
        end

        // Fill counter
        if (FIFO_FLUSH) begin
            d.fill = RDIRQ_RST_FILL;
        end else if (push_ok) begin
            d.fill = q.fill + 10'h001;
        end else if (pop_ok) begin
            d.fill = q.fill - 10'h001;
        end

        // Enable register writes
        if (wr && acc_addr == RDIRQ_ADDR_EN_A) begin
            d.en_a = HOST_WDATA;
        end
        if (wr && acc_addr == RDIRQ_ADDR_EN_B) begin
            d.en_b = HOST_WDATA;
        end

        // Read data
        if (rd) begin
            case (acc_addr)
                RDIRQ_ADDR_FILL:   d.rdata = q.fill[7:0];
                RDIRQ_ADDR_DATA:   d.rdata = FIFO_RDATA;
                RDIRQ_ADDR_STAT_A: d.rdata = {1'b0, req_a};
                RDIRQ_ADDR_STAT_B: d.rdata = {1'b0, combined, req_b};
                RDIRQ_ADDR_EN_A:   d.rdata = q.en_a;
                RDIRQ_ADDR_EN_B:   d.rdata = q.en_b;
                default:           d.rdata = 8'h00;
            endcase
        end

        // Push-pull drives always; open-drain only pulls low
        if (q.en_b[RDIRQ_PUSHPULL_BIT]) begin
            d.pin_o  = pin_level;
            d.pin_oe = 1'b1;
        end else begin
            d.pin_o  = 1'b0;
            d.pin_oe = ~pin_level;
        end
    end

    // State register; level detectors leave reset high, so no false alert edge follows
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            q <= '{ptr: 8'h00, fill: RDIRQ_RST_FILL, en_a: RDIRQ_RST_EN,
                   en_b: RDIRQ_RST_EN, hi_prev: 1'b1, lo_prev: 1'b1,
                   err_prev: 5'h00, rdata: 8'h00, rvalid: 1'b0, push: 1'b0,
                   wdata: 8'h00, pin_o: 1'b0, pin_oe: 1'b0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign HOST_RDATA       = q.rdata;
    assign HOST_RVALID      = q.rvalid;
    assign FIFO_PUSH        = q.push;
    assign FIFO_WDATA       = q.wdata;
    assign FIFO_POP         = data_rd;
    assign FILL_COUNT_EXT   = q.fill[9:8];
    assign HIGH_LEVEL_LIVE  = hi_live;
    assign LOW_LEVEL_LIVE   = lo_live;
    assign COMBINED_REQUEST = combined;
    assign IRQ_O            = q.pin_o;
    assign IRQ_OE           = q.pin_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_fill_read;
        rd && acc_addr == RDIRQ_ADDR_FILL ##1 HOST_RVALID;
    endsequence

    a_fill_read: assert property (s_fill_read |-> HOST_RDATA == $past(q.fill[7:0]))
        else $error("Fill count read wrong");
    a_push_count: assert property ((push_ok && !FIFO_FLUSH)
        |=> q.fill == $past(q.fill) + 10'h001 && FIFO_PUSH)
        else $error("Push did not count up");
    a_pop_count: assert property ((pop_ok && !FIFO_FLUSH) |=> q.fill == $past(q.fill) - 10'h001)
        else $error("Pop did not count down");
    a_ptr_hold: assert property ((wr || rd) && acc_addr == RDIRQ_ADDR_DATA
        |=> q.ptr == RDIRQ_ADDR_DATA)
        else $error("Pointer left the data port");
    a_ptr_step: assert property ((wr || rd) && acc_addr != RDIRQ_ADDR_DATA
        |=> q.ptr == $past(acc_addr) + 8'h01)
        else $error("Pointer did not advance");
    a_hi_latch: assert property ($rose(hi_live) |=> req_a[6] and
        (!(wr && acc_addr == RDIRQ_ADDR_STAT_A) |=> req_a[6]))
        else $error("High-level request not latched");
    a_lo_latch: assert property ($rose(lo_live) |=> req_a[5])
        else $error("Low-level request not latched");
    a_err_latch: assert property (|(EVENTS.error_flags & ~q.err_prev) |=> req_a[1])
        else $error("Error request not set");
    a_timer_set: assert property (EVENTS.timer_underflow[0] |=> req_b[0])
        else $error("Timer request not set");
    a_pin_gate: assert property (!q.en_b[RDIRQ_PINEN_BIT] && !q.en_a[RDIRQ_INV_BIT]
        && q.en_b[RDIRQ_PUSHPULL_BIT] && $stable(q.en_b) |=> !IRQ_O)
        else $error("Pin active while disabled");
    a_pin_invert: assert property (pin_active && q.en_a[RDIRQ_INV_BIT]
        && q.en_b[RDIRQ_PUSHPULL_BIT] |=> IRQ_OE && !IRQ_O)
        else $error("Pin polarity not inverted");
    a_open_drain: assert property (!q.en_b[RDIRQ_PUSHPULL_BIT] |=> !IRQ_O)
        else $error("Open-drain pin drove high");
    a_global_fall: assert property ((req_a & q.en_a[6:0]) == '0
        && (req_b & q.en_b[5:0]) == '0 |-> !COMBINED_REQUEST)
        else $error("Combined request stuck");

    // Each event sets its own request bit one edge later
    a_cmd_set: assert property ((EVENTS.cmd_self_end | EVENTS.cmd_unknown)
        |=> req_a[4])
        else $error("Command request lost");

    a_tx_set: assert property (EVENTS.tx_done |=> req_a[3])
        else $error("Transmit request lost");

    a_rx_set: assert property (EVENTS.rx_done |=> req_a[2])
        else $error("Receive request lost");

    a_sof_set: assert property (EVENTS.frame_start |=> req_a[0])
        else $error("Frame-start request lost");

    a_card_set: assert property (EVENTS.card_detect |=> req_b[5])
        else $error("Card request lost");

    a_timer_all: assert property (|EVENTS.timer_underflow
        |=> (req_b[4:0] & $past(EVENTS.timer_underflow)) == $past(EVENTS.timer_underflow))
        else $error("Timer request lost");

    // Enabled event raises the combined request
    sequence s_tx_enabled;
        EVENTS.tx_done && q.en_a[3] && !(wr && acc_addr == RDIRQ_ADDR_EN_A);
    endsequence

    a_global_rise: assert property (s_tx_enabled |=> COMBINED_REQUEST)
        else $error("Enabled request not combined");

    // Second status register shows the combined request at bit 6
    sequence s_stat_b_read;
        rd && acc_addr == RDIRQ_ADDR_STAT_B ##1 HOST_RVALID;
    endsequence

    a_stat_b_read: assert property (s_stat_b_read
        |-> HOST_RDATA[7:6] == {1'b0, $past(combined)})
        else $error("Combined request misread");

    // Live levels at the ends of the count
    a_lo_empty: assert property (q.fill == 10'h000 |-> LOW_LEVEL_LIVE)
        else $error("Low level missed");

    a_hi_small: assert property (BUF_SIZE_SEL && q.fill == RDIRQ_CAP_SMALL
        |-> HIGH_LEVEL_LIVE)
        else $error("High level missed");

    // Refused pushes and pops leave the count alone
    a_fill_full: assert property (data_wr && q.fill == cap && !FIFO_FLUSH
        |=> q.fill == $past(q.fill))
        else $error("Count passed capacity");

    a_fill_empty: assert property (data_rd && q.fill == 10'h000 && !FIFO_FLUSH
        |=> q.fill == 10'h000)
        else $error("Count went below zero");

    a_flush_zero: assert property (FIFO_FLUSH |=> q.fill == RDIRQ_RST_FILL)
        else $error("Flush left a count");

    // Buffer strobes and bytes
    a_push_data: assert property (data_wr
        |=> FIFO_PUSH && FIFO_WDATA == $past(HOST_WDATA))
        else $error("Pushed byte wrong");

    a_port_read: assert property (data_rd |=> HOST_RDATA == $past(FIFO_RDATA))
        else $error("Port byte wrong");

    // Pin driver levels
    a_push_pull: assert property (q.en_b[RDIRQ_PUSHPULL_BIT] |=> IRQ_OE)
        else $error("Push-pull pin not driven");

    a_pin_idle: assert property (!pin_active && !q.en_a[RDIRQ_INV_BIT]
        |=> IRQ_OE && !IRQ_O)
        else $error("Idle pin not low");

endmodule // rdirq_top

//--- hw/rdirq_pkg.sv
/*
 * Package of the request-status and buffer-port block: register offsets,
 * field positions, reset values, buffer capacities and carrier types.
 * Assumes a single system clock and a byte-wide host register port.
 */
package rdirq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] RDIRQ_ADDR_FILL   = 8'h04;
    localparam logic [7:0] RDIRQ_ADDR_DATA   = 8'h05;
    localparam logic [7:0] RDIRQ_ADDR_STAT_A = 8'h06;
    localparam logic [7:0] RDIRQ_ADDR_STAT_B = 8'h07;
    localparam logic [7:0] RDIRQ_ADDR_EN_A   = 8'h08;
    localparam logic [7:0] RDIRQ_ADDR_EN_B   = 8'h09;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int RDIRQ_SETOP_BIT    = 7;  // Set/clear select in status writes
    localparam int RDIRQ_INV_BIT      = 7;  // Pin polarity in enable A
    localparam int RDIRQ_PINEN_BIT    = 6;  // Pin enable in enable B
    localparam int RDIRQ_PUSHPULL_BIT = 7;  // Driver select in enable B
    localparam int RDIRQ_REQ_A_W      = 7;
    localparam int RDIRQ_REQ_B_W      = 6;
    localparam int RDIRQ_ERR_W        = 5;
    localparam int RDIRQ_TMR_W        = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and capacities
    localparam logic [9:0] RDIRQ_RST_FILL   = 10'h000;
    localparam logic [7:0] RDIRQ_RST_EN     = 8'h00;
    localparam logic [9:0] RDIRQ_CAP_SMALL  = 10'h0FF;
    localparam logic [9:0] RDIRQ_CAP_LARGE  = 10'h200;

    ////////////////////////////////////////////////////////////////////////////
    // Event carrier from the surrounding frontend
    typedef struct packed {
        logic                   frame_start;     // Start symbol or subcarrier seen
        logic [RDIRQ_ERR_W-1:0] error_flags;     // Levels of the five error flags
        logic                   rx_done;
        logic                   tx_done;
        logic                   cmd_self_end;    // Command ended on its own
        logic                   cmd_unknown;     // Unknown command fell to idle
        logic                   card_detect;
        logic [RDIRQ_TMR_W-1:0] timer_underflow;
    } rdirq_events_s;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]             ptr;
        logic [9:0]             fill;
        logic [7:0]             en_a;
        logic [7:0]             en_b;
        logic                   hi_prev;
        logic                   lo_prev;
        logic [RDIRQ_ERR_W-1:0] err_prev;
        logic [7:0]             rdata;
        logic                   rvalid;
        logic                   push;
        logic [7:0]             wdata;
        logic                   pin_o;
        logic                   pin_oe;
    } rdirq_state_s;

endpackage : rdirq_pkg

//--- hw/rdirq_req_bank.sv
/*
 * Bank of latched request bits with the set/clear write mechanism.
 * Assumes write strobe and events come from logic on the same clock.
 */
`timescale 1ns/1ps

module rdirq_req_bank
    import rdirq_pkg::*;
#(
    parameter int W = 7
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         wr,
    input  wire logic [7:0]   wdata,
    input  wire logic [W-1:0] set_ev,
    output logic      [W-1:0] req
);

    typedef struct packed {
        logic [W-1:0] bits;
    } rdirq_bank_s;

    rdirq_bank_s q;
    rdirq_bank_s d;

    // Elaboration check on the bank width
    if (W < 1 || W > RDIRQ_SETOP_BIT) begin : g_bad_width
        $error("Request bank width out of range");
    end

    // Host write sets or clears marked bits; hardware events win last
    always_comb begin
        d = q;
        if (wr) begin
            if (wdata[RDIRQ_SETOP_BIT]) begin
                d.bits = q.bits | wdata[W-1:0];
            end else begin
                d.bits = q.bits & ~wdata[W-1:0];
            end
        end
        d.bits = d.bits | set_ev;
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign req = q.bits;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_event_wins: assert property ((|set_ev) |=> ((req & $past(set_ev)) == $past(set_ev)))
        else $error("Event lost against clear");
    a_clear_marked: assert property ((wr && !wdata[7] && set_ev == '0)
        |=> ((req & $past(wdata[W-1:0])) == '0))
        else $error("Clear write left a bit set");
    a_zero_keeps: assert property ((wr && set_ev == '0)
        |=> ((req & ~$past(wdata[W-1:0])) == ($past(req) & ~$past(wdata[W-1:0]))))
        else $error("Unmarked bit changed");

endmodule // rdirq_req_bank

//--- sim/rdirq_buf_model.sv
/*
 * Behavioural model of the external byte buffer behind the data port.
 * Assumes push, pop and flush come from the block on the same clock.
 */
`timescale 1ns/1ps

module rdirq_buf_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       push,
    input  wire logic [7:0] wdata,
    input  wire logic       pop,
    input  wire logic       flush,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:1023];
    logic [9:0] wp_q;
    logic [9:0] rp_q;
    logic [7:0] last_q;

    ////////////////////////////////////////////////////////////////////////////
    // Storage, head byte shown ahead of pop
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wp_q   <= 10'h000;
            rp_q   <= 10'h000;
            last_q <= 8'h00;
        end else begin
            if (push) begin
                mem[wp_q] <= wdata;
                wp_q      <= wp_q + 10'h001;
            end
            if (pop && wp_q != rp_q) begin
                rp_q   <= rp_q + 10'h001;
                last_q <= mem[rp_q];
            end
        end
    end

    // Empty buffer shows no stale byte
    assign rdata = (wp_q != rp_q) ? mem[rp_q] : ~last_q;
endmodule // rdirq_buf_model

//--- sim/tb_top.sv
/*
 * Self-checking bench of the request-status and buffer-port block.
 * Assumes the design package is compiled first; bench acts as host.
 */
`timescale 1ns/1ps

module tb_top
    import rdirq_pkg::*;
;
    logic          SYS_CLK, RST_N, HOST_ADDR_LD, HOST_WR, HOST_RD;
    logic [7:0]    HOST_ADDR, HOST_WDATA, HOST_RDATA, FIFO_WDATA, FIFO_RDATA;
    logic          HOST_RVALID, FIFO_PUSH, FIFO_POP, FIFO_FLUSH, BUF_SIZE_SEL;
    logic [8:0]    LEVEL_THRESHOLD;
    logic [1:0]    FILL_COUNT_EXT;
    logic          HIGH_LEVEL_LIVE, LOW_LEVEL_LIVE, COMBINED_REQUEST, IRQ_O, IRQ_OE;
    rdirq_events_s EVENTS;
    int            n_fail, check_count, cyc, i;
    logic [7:0]    ea, eb;

    rdirq_top i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HOST_ADDR_LD(HOST_ADDR_LD),
        .HOST_ADDR(HOST_ADDR), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
        .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
        .FIFO_PUSH(FIFO_PUSH), .FIFO_WDATA(FIFO_WDATA), .FIFO_POP(FIFO_POP),
        .FIFO_RDATA(FIFO_RDATA), .FIFO_FLUSH(FIFO_FLUSH), .BUF_SIZE_SEL(BUF_SIZE_SEL),
        .LEVEL_THRESHOLD(LEVEL_THRESHOLD), .FILL_COUNT_EXT(FILL_COUNT_EXT),
        .HIGH_LEVEL_LIVE(HIGH_LEVEL_LIVE), .LOW_LEVEL_LIVE(LOW_LEVEL_LIVE),
        .EVENTS(EVENTS), .COMBINED_REQUEST(COMBINED_REQUEST), .IRQ_O(IRQ_O),
        .IRQ_OE(IRQ_OE));

    rdirq_buf_model i_buf (.clk(SYS_CLK), .rst_n(RST_N), .push(FIFO_PUSH),
        .wdata(FIFO_WDATA), .pop(FIFO_POP), .flush(FIFO_FLUSH), .rdata(FIFO_RDATA));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checking and host access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One register write, held for one taking edge
    task automatic wr(input logic [7:0] a, input logic ld, input logic [7:0] d);
        @(posedge SYS_CLK);
        HOST_ADDR_LD <= ld;
        HOST_ADDR    <= a;
        HOST_WDATA   <= d;
        HOST_WR      <= 1'b1;
        @(posedge SYS_CLK);
        HOST_ADDR_LD <= 1'b0;
        HOST_WR      <= 1'b0;
    endtask

    // One register read, data compared in its valid cycle
    task automatic rdc(input logic [7:0] a, input logic ld, input logic [7:0] exp);
        @(posedge SYS_CLK);
        HOST_ADDR_LD <= ld;
        HOST_ADDR    <= a;
        HOST_RD      <= 1'b1;
        @(posedge SYS_CLK);
        HOST_ADDR_LD <= 1'b0;
        HOST_RD      <= 1'b0;
        #1;
        chk((HOST_RVALID === 1'b1) ? HOST_RDATA : 8'hXX, exp);
    endtask

    task automatic ev(input logic [15:0] v);
        @(posedge SYS_CLK);
        EVENTS <= rdirq_events_s'(v);
        @(posedge SYS_CLK);
        EVENTS <= rdirq_events_s'(16'h0000);
    endtask

    // Pin is registered one cycle behind the registers
    task automatic pin(input logic o, input logic oe);
        @(posedge SYS_CLK);
        #1;
        chk({6'h00, IRQ_O, IRQ_OE}, {6'h00, o, oe});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {RST_N, HOST_ADDR_LD, HOST_WR, HOST_RD, FIFO_FLUSH, BUF_SIZE_SEL} = '0;
        {HOST_ADDR, HOST_WDATA, LEVEL_THRESHOLD} = '0;
        EVENTS = rdirq_events_s'(16'h0000);
        {n_fail, check_count, cyc} = '0;
        repeat (6) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        // Reset values, refused write, unmapped read
        rdc(8'h04, 1'b1, 8'h00);
        rdc(8'h06, 1'b1, 8'h00);
        rdc(8'h07, 1'b1, 8'h00);
        rdc(8'h08, 1'b1, 8'h00);
        rdc(8'h09, 1'b1, 8'h00);
        rdc(8'h10, 1'b1, 8'h00);
        wr(8'h04, 1'b1, 8'h55);
        rdc(8'h04, 1'b1, 8'h00);
        chk({6'h00, FILL_COUNT_EXT}, 8'h00);
        // Set and clear by bit 7
        wr(8'h06, 1'b1, 8'h7F);
        rdc(8'h06, 1'b1, 8'h00);
        wr(8'h06, 1'b1, 8'hFF);
        rdc(8'h06, 1'b1, 8'h7F);
        wr(8'h06, 1'b1, 8'h01);
        rdc(8'h06, 1'b1, 8'h7E);
        wr(8'h06, 1'b1, 8'h7F);
        wr(8'h06, 1'b1, 8'h85);
        rdc(8'h06, 1'b1, 8'h05);
        wr(8'h06, 1'b1, 8'h7F);
        wr(8'h07, 1'b1, 8'hFF);
        rdc(8'h07, 1'b1, 8'h3F);
        wr(8'h07, 1'b1, 8'h7F);
        rdc(8'h07, 1'b1, 8'h00);
        // Every event input, one at a time
        for (i = 0; i < 16; i++) begin
            ea = 8'h00;
            eb = 8'h00;
            if (i < 6) eb[i] = 1'b1;
            else if (i < 8) ea[4] = 1'b1;
            else if (i == 8) ea[3] = 1'b1;
            else if (i == 9) ea[2] = 1'b1;
            else if (i < 15) ea[1] = 1'b1;
            else ea[0] = 1'b1;
            ev(16'h0001 << i);
            rdc(8'h06, 1'b1, ea);
            rdc(8'h07, 1'b1, eb);
            wr(8'h06, 1'b1, 8'h7F);
            wr(8'h07, 1'b1, 8'h7F);
        end
        // Hardware set and host clear in one cycle
        @(posedge SYS_CLK);
        {HOST_ADDR_LD, HOST_WR} <= 2'b11;
        HOST_ADDR  <= 8'h06;
        HOST_WDATA <= 8'h08;
        EVENTS     <= rdirq_events_s'(16'h0100);
        @(posedge SYS_CLK);
        {HOST_ADDR_LD, HOST_WR} <= 2'b00;
        EVENTS <= rdirq_events_s'(16'h0000);
        rdc(8'h06, 1'b1, 8'h08);
        // Enables, combined request and pin driver
        wr(8'h08, 1'b1, 8'h08);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h01);
        rdc(8'h07, 1'b1, 8'h40);
        pin(1'b0, 1'b1);
        wr(8'h09, 1'b1, 8'h40);
        pin(1'b0, 1'b0);
        wr(8'h09, 1'b1, 8'hC0);
        pin(1'b1, 1'b1);
        wr(8'h08, 1'b1, 8'h88);
        pin(1'b0, 1'b1);
        wr(8'h08, 1'b1, 8'h80);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h00);
        pin(1'b1, 1'b1);
        wr(8'h07, 1'b1, 8'h84);
        wr(8'h09, 1'b1, 8'hC4);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h01);
        wr(8'h09, 1'b1, 8'hC0);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h00);
        wr(8'h08, 1'b1, 8'h88);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h01);
        wr(8'h06, 1'b1, 8'h08);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h00);
        ev(16'h0100);
        #1 chk({7'h00, COMBINED_REQUEST}, 8'h01);
        // Data port bursts keep the pointer, others advance it
        wr(8'h05, 1'b1, 8'hA5);
        wr(8'h00, 1'b0, 8'h3C);
        wr(8'h00, 1'b0, 8'h0F);
        rdc(8'h04, 1'b1, 8'h03);
        rdc(8'h05, 1'b1, 8'hA5);
        rdc(8'h00, 1'b0, 8'h3C);
        rdc(8'h00, 1'b0, 8'h0F);
        rdc(8'h04, 1'b1, 8'h00);
        rdc(8'h08, 1'b1, 8'h88);
        rdc(8'h00, 1'b0, 8'hC0);
        // Large buffer fill, level alerts, flush
        @(posedge SYS_CLK);
        LEVEL_THRESHOLD <= 9'h0D4;
        wr(8'h06, 1'b1, 8'h7F);
        for (i = 0; i < 300; i++)
            wr(8'h05, (i == 0), i[7:0]);
        repeat (2) @(posedge SYS_CLK);
        #1 chk({6'h00, FILL_COUNT_EXT}, 8'h01);
        chk({6'h00, HIGH_LEVEL_LIVE, LOW_LEVEL_LIVE}, 8'h02);
        rdc(8'h04, 1'b1, 8'h2C);
        rdc(8'h06, 1'b1, 8'h40);
        @(posedge SYS_CLK);
        FIFO_FLUSH <= 1'b1;
        @(posedge SYS_CLK);
        FIFO_FLUSH <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1 chk({6'h00, HIGH_LEVEL_LIVE, LOW_LEVEL_LIVE}, 8'h01);
        rdc(8'h06, 1'b1, 8'h60);
        rdc(8'h05, 1'b1, 8'hFF);
        rdc(8'h04, 1'b1, 8'h00);
        // Small buffer saturates at its capacity
        @(posedge SYS_CLK);
        BUF_SIZE_SEL <= 1'b1;
        for (i = 0; i < 256; i++)
            wr(8'h05, (i == 0), i[7:0]);
        rdc(8'h04, 1'b1, 8'hFF);
        chk({6'h00, HIGH_LEVEL_LIVE, LOW_LEVEL_LIVE}, 8'h02);
        tally_and_finish();
    end
endmodule // tb_top
